// ---- sfp_regs.vh ----
// Purpose: constants for the serial frame port with ready
// Assumes: 100 MHz system clock, link clock sampled as plain input
// Notes: bit counts are falling serial clock edges within one frame
`ifndef SFP_REGS_VH
`define SFP_REGS_VH

// frame positions (falling serial clock edges)
`define SFP_LAST_OUT_EDGE 5'h0E
`define SFP_END_EDGE 5'h0F
`define SFP_READY_EDGE 5'h10
`define SFP_CNT_W 5

// frame length in bits kept by the shifter
`define SFP_FRAME_BITS 16
`define SFP_FRAME_W 5'h10

// reset values
`define SFP_SHIFT_RST 16'h0000
`define SFP_ERR_RST 8'h00

// error register layout inside the received frame
`define SFP_RD_ERR_BIT 15
`define SFP_ERR_W 8

`endif

// ---- sfp_sync.v ----
// Purpose: two flip-flop synchroniser for one level from outside the clock domain
// Assumes: single-bit asynchronous input
// Notes: first stage is read only by the second stage
`timescale 1ns/1ns
`default_nettype none

module sfp_sync #(
  parameter RST_VAL = 1'b0
) (
  input wire i_clk,
  input wire i_rstn,
  input wire i_ce,
  input wire i_d,
  output wire o_q
);

  reg meta_q;
  reg sync_q;

  // ----------------------------------------
  // two stage capture
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else if (i_ce) begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;

endmodule // sfp_sync

`default_nettype wire

// ---- sfp_shift.v ----
// Purpose: frame shifter, samples data in and presents data out
// Assumes: sample and output strobes come from edge detection on the synchronised serial clock; the load strobe comes from select
// Notes: data out changes only on the load or the output strobe
`timescale 1ns/1ns
`default_nettype none
`include "sfp_regs.vh"

module sfp_shift (
  input wire i_clk,
  input wire i_rstn,
  input wire i_ce,
  input wire i_load,
  input wire [`SFP_FRAME_BITS-1:0] i_load_data,
  input wire i_sample,
  input wire i_din,
  input wire i_shift_out,
  output wire [`SFP_FRAME_BITS-1:0] o_rx,
  output wire o_dout
);

  reg [`SFP_FRAME_BITS-1:0] rx_q;
  reg [`SFP_FRAME_BITS-1:0] tx_q;
  reg dout_q;

  // ----------------------------------------
  // receive and transmit shifters
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_q <= `SFP_SHIFT_RST;
      tx_q <= `SFP_SHIFT_RST;
      dout_q <= 1'b0;
    end else if (i_ce) begin
      if (i_sample) begin
        rx_q <= {rx_q[`SFP_FRAME_BITS-2:0], i_din};
      end
      if (i_load) begin
        tx_q <= i_load_data;
        dout_q <= i_load_data[`SFP_FRAME_BITS-1];
      end else if (i_shift_out) begin
        tx_q <= {tx_q[`SFP_FRAME_BITS-2:0], 1'b0};
        dout_q <= tx_q[`SFP_FRAME_BITS-2];
      end
    end
  end

  assign o_rx = rx_q;
  assign o_dout = dout_q;

endmodule // sfp_shift

`default_nettype wire

// ---- sfp_port.v ----
// Purpose: serial frame port of an output conditioner, device side
// Assumes: host is the serial master; all pins sampled by i_clk at 100 MHz
// Notes: output enables are active low; chip select effects act within
//   the sampling delay of the system clock rather than truly asynchronously
//   the error flag enable is registered so the open-drain pin cannot glitch
//   a frame counts as complete only after its 16th falling serial edge
`timescale 1ns/1ns
`default_nettype none
`include "sfp_regs.vh"

module sfp_port (
  input wire i_clk,
  input wire i_rstn,
  input wire i_ce,
  input wire i_sclk,
  input wire i_din,
  input wire i_chip_select_a_n,
  input wire i_chip_select_b_n,
  input wire [`SFP_ERR_W-1:0] i_err_event,
  output wire o_dout,
  output wire o_dout_oe_n,
  output wire o_ready_n,
  output wire o_err_flag_out,
  output wire o_err_flag_oe_n,
  output wire [`SFP_FRAME_BITS-1:0] o_frame,
  output wire o_frame_valid
);

  // ----------------------------------------
  // state codes
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_BITS = 3'h2;
  localparam [2:0] ST_DONE = 3'h4;

  wire sclk_s;
  wire csa_s;
  wire csb_s;
  wire din_s;
  wire sel_n;
  wire sclk_fall;
  wire sample;
  wire [`SFP_FRAME_BITS-1:0] rx;
  wire sh_dout;
  reg sclk_prev_q;
  reg sel_prev_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [`SFP_CNT_W-1:0] cnt_q;
  reg oe_n_q;
  reg ready_n_q;
  reg [`SFP_ERR_W-1:0] err_q;
  reg [`SFP_ERR_W-1:0] err_snap_q;
  reg rd_err_q;
  reg [`SFP_FRAME_BITS-1:0] frame_q;
  reg frame_valid_q;
  reg err_oe_n_q;
  wire sel_start;
  wire frame_end;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // serial clock pin
  sfp_sync #(.RST_VAL(1'b0)) u_sync_sclk (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_d(i_sclk),
    .o_q(sclk_s)
  );

  // first select pin, deselected after reset
  sfp_sync #(.RST_VAL(1'b1)) u_sync_csa (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_d(i_chip_select_a_n),
    .o_q(csa_s)
  );

  // second select pin, deselected after reset
  sfp_sync #(.RST_VAL(1'b1)) u_sync_csb (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_d(i_chip_select_b_n),
    .o_q(csb_s)
  );

  // serial data pin
  sfp_sync #(.RST_VAL(1'b0)) u_sync_din (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_d(i_din),
    .o_q(din_s)
  );

  // deselected when either select is high
  assign sel_n = csa_s | csb_s;

  // first cycle in which the selects are seen low
  assign sel_start = (state_q == ST_IDLE) & ~sel_n;
  // first deselected cycle after a complete frame
  assign frame_end = (state_q == ST_DONE) & sel_n & ~sel_prev_q;

  // ----------------------------------------
  // edge detection on the serial clock
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sclk_prev_q <= 1'b0;
      sel_prev_q <= 1'b1;
    end else if (i_ce) begin
      sclk_prev_q <= sclk_s;
      sel_prev_q <= sel_n;
    end
  end

  assign sclk_fall = sclk_prev_q & ~sclk_s;
  assign sample = sclk_fall & ~sel_n & (state_q == ST_BITS);

  // ----------------------------------------
  // frame state machine
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (!sel_n) begin
          state_d = ST_BITS;
        end
      end
      ST_BITS: begin
        if (sel_n) begin
          state_d = ST_IDLE;
        end else if (sclk_fall && cnt_q == `SFP_READY_EDGE - 5'h01) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        if (sel_n) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ST_IDLE;
    end else if (i_ce) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // falling edge count within the frame
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= 5'h00;
    end else if (i_ce) begin
      if (sel_n || sel_start) begin
        // count restarts with every frame
        cnt_q <= 5'h00;
      end else if (sample) begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // ----------------------------------------
  // data out enable
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      oe_n_q <= 1'b1;
    end else if (i_ce) begin
      if (sel_n) begin
        oe_n_q <= 1'b1;
      end else if (sel_start) begin
        oe_n_q <= 1'b0;
      end else if (sample && cnt_q == `SFP_LAST_OUT_EDGE - 5'h01) begin
        oe_n_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // ready output
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ready_n_q <= 1'b1;
    end else if (i_ce) begin
      if (sel_n) begin
        ready_n_q <= 1'b1;
      end else if (sample && cnt_q == `SFP_READY_EDGE - 5'h01) begin
        ready_n_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // frame shifter
  // ----------------------------------------
  // output moves on falling edges
  sfp_shift u_shift (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_load(sel_start),
    .i_load_data({err_q, 8'h00}),
    .i_sample(sample),
    .i_din(din_s),
    .i_shift_out(sample),
    .o_rx(rx),
    .o_dout(sh_dout)
  );

  // ----------------------------------------
  // received frame and error flag
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      frame_q <= `SFP_SHIFT_RST;
      frame_valid_q <= 1'b0;
      err_q <= `SFP_ERR_RST;
      err_snap_q <= `SFP_ERR_RST;
      rd_err_q <= 1'b0;
      err_oe_n_q <= 1'b1;
    end else if (i_ce) begin
      frame_valid_q <= 1'b0;
      if (sel_start) begin
        err_snap_q <= err_q;
      end
      if (frame_end) begin
        frame_q <= rx;
        frame_valid_q <= 1'b1;
        rd_err_q <= rx[`SFP_RD_ERR_BIT];
      end else begin
        rd_err_q <= 1'b0;
      end
      // clear after read, new events win
      if (rd_err_q) begin
        err_q <= (err_q & ~err_snap_q) | i_err_event;
      end else begin
        err_q <= err_q | i_err_event;
      end
      // flag pulls low while any error is pending
      err_oe_n_q <= ~(|err_q);
    end
  end

  // ----------------------------------------
  // pin and status outputs
  // ----------------------------------------
  assign o_dout = sh_dout;
  assign o_dout_oe_n = oe_n_q;
  assign o_ready_n = ready_n_q;
  // open-drain data is always low; only the enable moves
  assign o_err_flag_out = 1'b0;
  assign o_err_flag_oe_n = err_oe_n_q;
  assign o_frame = frame_q;
  assign o_frame_valid = frame_valid_q;

endmodule // sfp_port

`default_nettype wire

// ---- sfp_port_props.sv ----
// Purpose: pin-level checks for the serial frame port
// Assumes: pins lag 3-4 i_clk cycles through the synchronisers
// Notes: serial falls are counted here from the raw pins
`timescale 1ns/1ns
`default_nettype none
module sfp_port_props (
  input wire i_clk,
  input wire i_rstn,
  input wire i_sclk,
  input wire i_din,
  input wire i_chip_select_a_n,
  input wire i_chip_select_b_n,
  input wire o_dout,
  input wire o_dout_oe_n,
  input wire o_ready_n,
  input wire [15:0] o_frame,
  input wire o_frame_valid
);
  // ----------
  // fall counter and checks
  // ----------
  logic sclk_q;
  logic [4:0] cnt_q;
  logic [15:0] rx_q;
  wire sel = !(i_chip_select_a_n || i_chip_select_b_n);
  // count raw serial falls in a frame and keep the sampled bits
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sclk_q <= 1'b1;
      cnt_q <= 5'h00;
      rx_q <= 16'h0000;
    end else begin
      sclk_q <= i_sclk;
      if (!sel) begin
        cnt_q <= 5'h00;
      end else if (sclk_q && !i_sclk && cnt_q < 5'h10) begin
        cnt_q <= cnt_q + 5'h01;
        rx_q <= {rx_q[14:0], i_din};
      end
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  float_desel_a: assert property (!sel [*5] |-> o_dout_oe_n)
    else $error("dout driven while deselected");
  enable_sel_a: assert property ($rose(sel) ##1 (sel && i_sclk) [*5] |-> !o_dout_oe_n)
    else $error("dout not enabled");
  dout_edge_a: assert property (!o_dout_oe_n && $past(!o_dout_oe_n) && $changed(o_dout)
    |-> $past(i_sclk, 6) && !$past(i_sclk, 2))
    else $error("dout moved off a fall");
  release_14_a: assert property ((cnt_q == 5'h0E) [*6] |-> o_dout_oe_n)
    else $error("dout not released");
  ready_16_a: assert property ((sel && cnt_q == 5'h10) [*6] |-> !o_ready_n)
    else $error("ready missing");
  no_early_a: assert property ((sel && cnt_q < 5'h10) [*6] |-> o_ready_n)
    else $error("ready too early");
  ready_rel_a: assert property (!sel [*5] |-> o_ready_n)
    else $error("ready held");
  frame_data_a: assert property (o_frame_valid |-> o_frame == rx_q)
    else $error("frame mismatch");
  cover property (o_frame_valid);
  cover property ($fell(o_ready_n));
  cover property (sel && $rose(o_dout_oe_n));
endmodule // sfp_port_props
`default_nettype wire

// ---- sfp_host.sv ----
// Purpose: behavioural host master for the serial frame port
// Assumes: driven from i_clk rising edges, 4 cycles per half period
// Notes: serial clock idles high and stands still between frames
`timescale 1ns/1ns
`default_nettype none
module sfp_host (
  input wire i_clk,
  input wire i_dout,
  input wire i_dout_oe_n,
  input wire i_ready_n,
  output logic o_sclk,
  output logic o_din,
  output logic o_cs_a_n,
  output logic o_cs_b_n
);
  // ----------
  // frame tasks
  // ----------
  logic [15:0] rx;
  logic ready_seen;
  // idle levels at time zero
  initial begin
    o_sclk = 1'b1;
    o_din = 1'b0;
    o_cs_a_n = 1'b1;
    o_cs_b_n = 1'b1;
    rx = 16'h0000;
    ready_seen = 1'b0;
  end
  // 80 ns clock inside the frame
  task automatic xfer(input logic [1:0] sel_n, input logic [15:0] d, input int n);
    @(posedge i_clk);
    o_cs_a_n <= sel_n[0];
    o_cs_b_n <= sel_n[1];
    repeat (4) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_din <= d[15 - i];
      repeat (4) @(posedge i_clk);
      rx = {rx[14:0], i_dout_oe_n ? 1'bz : i_dout};
      o_sclk <= 1'b0;
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b1;
    end
    repeat (4) @(posedge i_clk);
    ready_seen = !i_ready_n;
  endtask
  // selects rise well after the last fall
  task automatic done();
    o_cs_a_n <= 1'b1;
    o_cs_b_n <= 1'b1;
    o_din <= ~o_din;
    repeat (8) @(posedge i_clk);
  endtask
endmodule // sfp_host
`default_nettype wire

// ---- tb_sfp_port.sv ----
// Purpose: self-checking bench for the serial frame port
// Assumes: host model makes the serial clock from i_clk
// Notes: i_ce is held high throughout
`timescale 1ns/1ns
`default_nettype none
module tb_sfp_port;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [7:0] err_ev = 8'h00;
  wire sclk, din, cs_a_n, cs_b_n, dout, dout_oe_n, ready_n, err_oe_n, valid, err_out;
  wire [15:0] frame;
  int errors = 0;
  int checks_done = 0;
  int n_valid = 0;
  // ----------
  // clock, model, device and tests
  // ----------
  always #5 i_clk = ~i_clk;
  // count frame update pulses
  always @(posedge i_clk) begin
    if (valid === 1'b1) begin
      n_valid++;
    end
  end
  sfp_host host (.i_clk(i_clk), .i_dout(dout), .i_dout_oe_n(dout_oe_n), .i_ready_n(ready_n),
    .o_sclk(sclk),
    .o_din(din), .o_cs_a_n(cs_a_n), .o_cs_b_n(cs_b_n));
  sfp_port uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(1'b1), .i_sclk(sclk), .i_din(din),
    .i_chip_select_a_n(cs_a_n), .i_chip_select_b_n(cs_b_n), .i_err_event(err_ev),
    .o_dout(dout), .o_dout_oe_n(dout_oe_n), .o_ready_n(ready_n), .o_err_flag_out(err_out),
    .o_err_flag_oe_n(err_oe_n), .o_frame(frame), .o_frame_valid(valid));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic t_full();
    host.xfer(2'b00, 16'hA5C3, 16);
    chk(ready_n, 1'b0);
    host.done();
    chk(ready_n, 1'b1);
    chk(frame, 16'hA5C3);
    chk(n_valid, 1);
    chk(host.rx[15:2], 14'h0000);
    chk(host.rx[1:0], 2'bzz);
    chk(host.ready_seen, 1'b1);
    $display("full frame done");
  endtask
  task automatic t_short();
    host.xfer(2'b00, 16'h0F0F, 10);
    chk(ready_n, 1'b1);
    chk(host.ready_seen, 1'b0);
    host.done();
    chk(frame, 16'hA5C3);
    chk(n_valid, 1);
    $display("short frame done");
  endtask
  task automatic t_desel();
    for (int m = 1; m < 3; m++) begin
      host.xfer(m[1:0], 16'hFFFF, 8);
      chk(dout_oe_n, 1'b1);
      host.done();
    end
    chk(n_valid, 1);
    $display("half select done");
  endtask
  task automatic t_err();
    err_ev <= 8'h24;
    @(posedge i_clk);
    err_ev <= 8'h00;
    repeat (4) @(posedge i_clk);
    chk(err_oe_n, 1'b0);
    chk(err_out, 1'b0);
    host.xfer(2'b00, 16'h4000, 16);
    host.done();
    chk(host.rx[15:2], 14'h0900);
    chk(err_oe_n, 1'b0);
    chk(frame, 16'h4000);
    host.xfer(2'b00, 16'h8000, 16);
    host.done();
    chk(host.rx[15:2], 14'h0900);
    chk(err_oe_n, 1'b1);
    chk(frame, 16'h8000);
    $display("error read done");
  endtask
  // reset, then the tests in order
  initial begin
    repeat (2) @(posedge i_clk);
    chk(dout_oe_n, 1'b1);
    chk(ready_n, 1'b1);
    chk(err_oe_n, 1'b1);
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_full();
    t_short();
    t_desel();
    t_err();
    report_and_stop();
  end
  // watchdog against a hang
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
endmodule // tb_sfp_port
bind sfp_port sfp_port_props u_props (.i_clk(i_clk), .i_rstn(i_rstn), .i_sclk(i_sclk),
  .i_din(i_din), .i_chip_select_a_n(i_chip_select_a_n),
  .i_chip_select_b_n(i_chip_select_b_n), .o_dout(o_dout), .o_dout_oe_n(o_dout_oe_n),
  .o_ready_n(o_ready_n), .o_frame(o_frame), .o_frame_valid(o_frame_valid));
`default_nettype wire
